// file: hw/vkd_keyer.v
// one-keyer luma datapath: key control from cut, mask, opacity, mix over background
// assumes one sample per clock on all video inputs, all aligned, and an APB master
`timescale 1ns/10ps
`include "vkd_defs.vh"

module vkd_keyer #(
	parameter DW = 10,
	parameter PMAX = 4,
	parameter SMAX = 3
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire vid_valid,
	input wire [DW-1:0] bg_pix,
	input wire [DW-1:0] cut_pix,
	input wire [DW-1:0] fill_pix,
	input wire [DW-1:0] wipe_mask,
	input wire [DW-1:0] mask_vid,
	output reg out_valid,
	output reg [DW-1:0] out_pix,
	output reg [DW-1:0] key_monitor
);

localparam [DW-1:0] FS = {DW{1'b1}};
localparam LEN = 2 * PMAX + SMAX + 1;
localparam [3:0] PW = 4'h4;
localparam SW = 13;
localparam [PW-1:0] POS_TOP = 2 * PMAX;
localparam [1:0] SIZE_TOP = SMAX;

// ==========================================
// arithmetic helpers
function [DW-1:0] mul_norm;
	input [DW-1:0] a;
	input [DW-1:0] b;
	reg [2*DW:0] p;
	reg [2*DW:0] q;
	begin
		// half-lsb bias turns the divide into round-to-nearest
		p = a * b + {1'b0, FS[DW-1:1]};
		q = p / FS;
		mul_norm = q[DW-1:0];
	end
endfunction

function [DW-1:0] clamp_s;
	input signed [SW-1:0] v;
	begin
		if (v <= 0) begin
			clamp_s = {DW{1'b0}};
		end else if (v >= $signed({3'b000, FS})) begin
			clamp_s = FS;
		end else begin
			clamp_s = v[DW-1:0];
		end
	end
endfunction

// ==========================================
// registers
reg [`VKD_CTRL_W-1:0] ctrl_r;
reg [DW-1:0] clip_r;
reg [DW:0] gain_r;
reg [DW-1:0] opac_r;
reg [PW-1:0] pos_r;
reg [1:0] size_r;
reg [DW-1:0] core_r;

wire acc_w = psel & penable & pready & pwrite;
wire signed [SW-1:0] clip_s = $signed({3'b000, clip_r});
wire signed [SW-1:0] gain_s = $signed({2'b00, gain_r});
wire signed [SW-1:0] half_s = gain_s >>> 1;
// upper takes the odd bit of gain, so upper minus lower is exactly gain
wire signed [SW-1:0] upper_s = clip_s + gain_s - half_s;
wire signed [SW-1:0] lower_s = clip_s - half_s;
wire signed [SW-1:0] wval_s = $signed({3'b000, pwdata[DW-1:0]});
reg signed [SW-1:0] nlo_s;
reg signed [SW-1:0] nhi_s;
reg signed [SW-1:0] span_s;

always @* begin
	nlo_s = lower_s;
	nhi_s = upper_s;
	if (paddr == `VKD_OFF_UPPER) begin
		nhi_s = wval_s;
	end else begin
		nlo_s = wval_s;
	end
	span_s = nhi_s - nlo_s;
	if (span_s < 0) begin
		span_s = {SW{1'b0}};
	end
end

wire signed [SW-1:0] nclip_s = nlo_s + (span_s >>> 1);

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ctrl_r <= `VKD_RST_CTRL;
		clip_r <= `VKD_RST_CLIP;
		gain_r <= `VKD_RST_GAIN;
		opac_r <= `VKD_RST_OPAC;
		pos_r <= PMAX[PW-1:0];
		size_r <= `VKD_RST_SIZE;
		core_r <= `VKD_RST_CORE;
	end else if (acc_w) begin
		case (paddr)
		`VKD_OFF_CTRL: begin
			ctrl_r <= pwdata[`VKD_CTRL_W-1:0];
		end
		`VKD_OFF_CLIP: begin
			clip_r <= pwdata[DW-1:0];
		end
		`VKD_OFF_GAIN: begin
			gain_r <= pwdata[DW:0];
		end
		`VKD_OFF_UPPER, `VKD_OFF_LOWER: begin
			clip_r <= clamp_s(nclip_s);
			gain_r <= span_s[DW:0];
		end
		`VKD_OFF_OPAC: begin
			opac_r <= pwdata[DW-1:0];
		end
		`VKD_OFF_POS: begin
			// out-of-range positions clamp to POS_TOP, the last position at 2 * PMAX, short of the far end of the cut line
			if (pwdata[PW-1:0] > POS_TOP) begin
				pos_r <= POS_TOP;
			end else begin
				pos_r <= pwdata[PW-1:0];
			end
		end
		`VKD_OFF_SIZE: begin
			// narrowing cannot reach past the last tap of the cut line
			size_r <= (pwdata[1:0] > SIZE_TOP) ? SIZE_TOP : pwdata[1:0];
		end
		`VKD_OFF_CORE: begin
			core_r <= pwdata[DW-1:0];
		end
		default: begin
			ctrl_r <= ctrl_r;
		end
		endcase
	end
end

// ==========================================
// apb answer: registered during setup, so every access takes one wait-free cycle
reg [31:0] rd_nxt;
reg err_nxt;

always @* begin
	rd_nxt = 32'h0;
	err_nxt = 1'b0;
	case (paddr)
	`VKD_OFF_CTRL: rd_nxt[`VKD_CTRL_W-1:0] = ctrl_r;
	`VKD_OFF_CLIP: rd_nxt[DW-1:0] = clip_r;
	`VKD_OFF_GAIN: rd_nxt[DW:0] = gain_r;
	`VKD_OFF_UPPER: rd_nxt[SW-1:0] = upper_s;
	`VKD_OFF_LOWER: rd_nxt[SW-1:0] = lower_s;
	`VKD_OFF_OPAC: rd_nxt[DW-1:0] = opac_r;
	`VKD_OFF_POS: rd_nxt[PW-1:0] = pos_r;
	`VKD_OFF_SIZE: rd_nxt[1:0] = size_r;
	`VKD_OFF_CORE: rd_nxt[DW-1:0] = core_r;
	`VKD_OFF_STAT: rd_nxt[DW-1:0] = key_monitor;
	default: err_nxt = 1'b1;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h0;
		pready <= 1'b0;
		pslverr <= 1'b0;
	end else begin
		pready <= psel & ~penable;
		pslverr <= psel & ~penable & err_nxt;
		if (psel & ~penable) begin
			prdata <= rd_nxt;
		end
	end
end

// ==========================================
// alignment lines: fill sits at the centre tap, cut moves around it
reg [DW-1:0] cut_ln [0:LEN-1];
reg [DW-1:0] fill_ln [0:PMAX];
reg [DW-1:0] bg_ln [0:PMAX];
reg [DW-1:0] wm_ln [0:PMAX];
reg [DW-1:0] mv_ln [0:PMAX];
reg [PMAX:0] val_ln;
integer i;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		for (i = 0; i < LEN; i = i + 1) begin
			cut_ln[i] <= {DW{1'b0}};
		end
		for (i = 0; i <= PMAX; i = i + 1) begin
			fill_ln[i] <= {DW{1'b0}};
			bg_ln[i] <= {DW{1'b0}};
			wm_ln[i] <= {DW{1'b0}};
			mv_ln[i] <= {DW{1'b0}};
		end
		val_ln <= {(PMAX+1){1'b0}};
	end else begin
		cut_ln[0] <= cut_pix;
		fill_ln[0] <= fill_pix;
		bg_ln[0] <= bg_pix;
		wm_ln[0] <= wipe_mask;
		mv_ln[0] <= mask_vid;
		for (i = 1; i < LEN; i = i + 1) begin
			cut_ln[i] <= cut_ln[i-1];
		end
		for (i = 1; i <= PMAX; i = i + 1) begin
			fill_ln[i] <= fill_ln[i-1];
			bg_ln[i] <= bg_ln[i-1];
			wm_ln[i] <= wm_ln[i-1];
			mv_ln[i] <= mv_ln[i-1];
		end
		val_ln <= {val_ln[PMAX-1:0], vid_valid};
	end
end

// ==========================================
// stage 1: position and narrowing of the cut
// narrowing is a running minimum over older taps, so a bright shape loses edge pixels on its leading side only
reg [DW-1:0] cut_sel;
integer j;

always @* begin
	cut_sel = cut_ln[pos_r];
	for (j = 1; j <= SMAX; j = j + 1) begin
		if (j <= size_r && cut_ln[pos_r + j] < cut_sel) begin
			cut_sel = cut_ln[pos_r + j];
		end
	end
end

reg [DW-1:0] cut1_r, fill1_r, bg1_r, msk1_r;
reg v1_r;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cut1_r <= {DW{1'b0}};
		fill1_r <= {DW{1'b0}};
		bg1_r <= {DW{1'b0}};
		msk1_r <= {DW{1'b0}};
		v1_r <= 1'b0;
	end else begin
		cut1_r <= cut_sel;
		fill1_r <= fill_ln[PMAX];
		bg1_r <= bg_ln[PMAX];
		msk1_r <= ctrl_r[`VKD_CTRL_MSRC] ? mv_ln[PMAX] : wm_ln[PMAX];
		v1_r <= val_ln[PMAX];
	end
end

// ==========================================
// stage 2: transfer curve, shaping, invert, mask, opacity
// the divide is wide but one path serves both clip modes and linear keys alike
wire signed [SW-1:0] diff_s = $signed({3'b000, cut1_r}) - lower_s;
reg [DW-1:0] k_lin, k_s, k_m;
reg [3*DW+1:0] sc;
reg [2*DW+1:0] kq;
reg [3*DW+1:0] sq;

always @* begin
	kq = {(2*DW+2){1'b0}};
	if (gain_r == {(DW+1){1'b0}}) begin
		k_lin = (cut1_r >= clip_r) ? FS : {DW{1'b0}};
	end else if (diff_s <= 0) begin
		k_lin = {DW{1'b0}};
	end else if (diff_s >= $signed({2'b00, gain_r})) begin
		k_lin = FS;
	end else begin
		// wide product keeps the full ratio before the divide
		kq = diff_s[DW:0] * FS;
		kq = kq / gain_r;
		k_lin = kq[DW-1:0];
	end
	// smoothstep keeps both end points and the mid point, so thresholds stay put
	sc = k_lin * k_lin * (3 * FS - 2 * k_lin);
	sq = sc / (FS * FS);
	k_s = ctrl_r[`VKD_CTRL_SCRV] ? sq[DW-1:0] : k_lin;
	k_m = ctrl_r[`VKD_CTRL_INV] ? FS - k_s : k_s;
	if (msk1_r[DW-1]) begin
		if (ctrl_r[`VKD_CTRL_PROT]) begin
			k_m = {DW{1'b0}};
		end else if (ctrl_r[`VKD_CTRL_OVR]) begin
			k_m = FS;
		end
	end
end

reg [DW-1:0] k2_r, fill2_r, bg2_r;
reg v2_r;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		k2_r <= {DW{1'b0}};
		fill2_r <= {DW{1'b0}};
		bg2_r <= {DW{1'b0}};
		v2_r <= 1'b0;
	end else begin
		k2_r <= mul_norm(k_m, opac_r);
		fill2_r <= fill1_r;
		bg2_r <= bg1_r;
		v2_r <= v1_r;
	end
end

// ==========================================
// stage 3: mix
reg [DW-1:0] fterm;
reg [DW:0] sum;

always @* begin
	if (ctrl_r[`VKD_CTRL_ADD]) begin
		fterm = fill2_r;
	end else begin
		fterm = mul_norm(fill2_r, k2_r);
	end
	if (ctrl_r[`VKD_CTRL_CORE] && k2_r == {DW{1'b0}} && fill2_r < core_r) begin
		fterm = {DW{1'b0}};
	end
	sum = mul_norm(bg2_r, FS - k2_r) + fterm;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		out_pix <= {DW{1'b0}};
		key_monitor <= {DW{1'b0}};
		out_valid <= 1'b0;
	end else begin
		out_pix <= sum[DW] ? FS : sum[DW-1:0];
		key_monitor <= k2_r;
		out_valid <= v2_r;
	end
end

endmodule // vkd_keyer

// file: pkg/vkd_defs.vh
// register offsets, field positions and reset values of the keyer datapath
// assumes byte addressing on APB, one 32-bit word per register
`ifndef VKD_DEFS_VH
`define VKD_DEFS_VH

// ==========================================
// register offsets
`define VKD_OFF_CTRL 8'h00
`define VKD_OFF_CLIP 8'h04
`define VKD_OFF_GAIN 8'h08
`define VKD_OFF_UPPER 8'h0C
`define VKD_OFF_LOWER 8'h10
`define VKD_OFF_OPAC 8'h14
`define VKD_OFF_POS 8'h18
`define VKD_OFF_SIZE 8'h1C
`define VKD_OFF_CORE 8'h20
`define VKD_OFF_STAT 8'h24

// ==========================================
// control fields
`define VKD_CTRL_ADD 0
`define VKD_CTRL_TWO 1
`define VKD_CTRL_SCRV 2
`define VKD_CTRL_INV 3
`define VKD_CTRL_CORE 4
`define VKD_CTRL_PROT 5
`define VKD_CTRL_OVR 6
`define VKD_CTRL_MSRC 7
`define VKD_CTRL_W 8

// ==========================================
// reset values
`define VKD_RST_CTRL 8'h04
`define VKD_RST_CLIP 10'h200
`define VKD_RST_GAIN 11'h3FF
`define VKD_RST_OPAC 10'h3FF
`define VKD_RST_CORE 10'h040
`define VKD_RST_SIZE 2'h0

`endif

// file: bench/vkd_keyer_monitor.sv
// port checks of the keyer: apb handshake and video latency
// assumes one clock pclk and async active-low presetn
`timescale 1ns/10ps
module vkd_keyer_mon #(
	parameter PMAX = 4
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire vid_valid,
	input wire out_valid
);
	// outputs change after edge k+PMAX+3, so they are sampled one edge later
	localparam int LAT = PMAX + 4;
	logic [3:0] up_r;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========
	// cycles since reset, so delayed compares never look into reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up_r <= 4'h0;
		else if (up_r != 4'hF)
			up_r <= up_r + 4'h1;
	end
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready missing after setup");
	property p_acc; pready |-> psel && penable; endproperty
	a_acc: assert property (p_acc) else $error("ready outside access");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready held too long");
	property p_idle; !psel |=> !pready; endproperty
	a_idle: assert property (p_idle) else $error("ready without select");
	property p_set; pready |-> $past(psel) && !$past(penable); endproperty
	a_set: assert property (p_set) else $error("ready without setup");
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("bad error response");
	property p_hold; !(psel && !penable) |=> $stable(prdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_lat; up_r >= LAT |-> out_valid == $past(vid_valid, LAT); endproperty
	a_lat: assert property (p_lat) else $error("valid latency wrong");
endmodule // vkd_keyer_mon

bind vkd_keyer vkd_keyer_mon #(.PMAX(PMAX)) u_vkd_keyer_mon (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.vid_valid(vid_valid),
	.out_valid(out_valid)
);

// file: bench/vkd_vsrc.sv
// video source model: levels from the bench, valid toggles like blanking
// assumes the bench changes levels right after a rising edge
`timescale 1ns/10ps
module vkd_vsrc (
	input wire pclk,
	input wire presetn,
	input wire [9:0] cut_l,
	input wire [9:0] fill_l,
	input wire [9:0] bg_l,
	input wire [9:0] msk_l,
	output logic vid_valid,
	output logic [9:0] cut_pix,
	output logic [9:0] fill_pix,
	output logic [9:0] bg_pix,
	output logic [9:0] wipe_mask,
	output logic [9:0] mask_vid
);
	// mask video is the inverse of the wipe so the source select shows
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{vid_valid, cut_pix, fill_pix, bg_pix, wipe_mask, mask_vid} <= '0;
		end else begin
			vid_valid <= ~vid_valid;
			cut_pix <= cut_l;
			fill_pix <= fill_l;
			bg_pix <= bg_l;
			wipe_mask <= msk_l;
			mask_vid <= ~msk_l;
		end
	end
endmodule // vkd_vsrc

// file: bench/tb_top.sv
// bench for the keyer: apb register access and key/mix scenarios
// assumes the video model and the port checker are compiled alongside
`timescale 1ns/10ps
`include "vkd_defs.vh"
module tb_top;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	logic err;
	logic [9:0] cut_l = 10'h0;
	logic [9:0] fill_l = 10'h0;
	logic [9:0] msk_l = 10'h0;
	wire [31:0] prdata;
	wire pready, pslverr, vid_valid, out_valid;
	wire [9:0] bg_pix, cut_pix, fill_pix, wipe_mask, mask_vid, out_pix, key_monitor;
	int fails = 0;
	int checks_done = 0;
	localparam int PMAX_TB = 4;
	always #5 pclk = ~pclk;
	vkd_vsrc u_vkd_vsrc (.pclk(pclk), .presetn(presetn), .cut_l(cut_l), .fill_l(fill_l),
		.bg_l(10'h300), .msk_l(msk_l), .vid_valid(vid_valid), .cut_pix(cut_pix),
		.fill_pix(fill_pix), .bg_pix(bg_pix), .wipe_mask(wipe_mask), .mask_vid(mask_vid));
	vkd_keyer u_vkd_keyer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .vid_valid(vid_valid), .bg_pix(bg_pix), .cut_pix(cut_pix),
		.fill_pix(fill_pix), .wipe_mask(wipe_mask), .mask_vid(mask_vid),
		.out_valid(out_valid), .out_pix(out_pix), .key_monitor(key_monitor));
	// ==========
	// shared tasks
	task automatic give_verdict;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			give_verdict;
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		chk(rd, e);
	endtask
	// fixed wait covers model stage plus the pipeline latency
	task automatic pix(input logic [9:0] c, f, m, ek, eo);
		cut_l <= c;
		fill_l <= f;
		msk_l <= m;
		repeat (12) @(posedge pclk);
		chk(32'(key_monitor), 32'(ek));
		chk(32'(out_pix), 32'(eo));
	endtask
	// partial keys round per product, so one code of slack is allowed
	task automatic chk_near(input logic [31:0] got, input logic [31:0] exp, input int tol);
		checks_done++;
		if ($isunknown(got) || got > exp + tol || got + tol < exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic pixn(input logic [9:0] c, f, m, ek, eo);
		cut_l <= c;
		fill_l <= f;
		msk_l <= m;
		repeat (12) @(posedge pclk);
		chk_near(32'(key_monitor), 32'(ek), 1);
		chk_near(32'(out_pix), 32'(eo), 1);
	endtask
	// counts edges from a cut step to the first keyed sample on the monitor
	task automatic rise(input int e);
		int n;
		cut_l <= 10'h0;
		repeat (16) @(posedge pclk);
		cut_l <= 10'h3FF;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (key_monitor == 10'h0 && n < 40);
		if (n >= 40) begin
			fails++;
			give_verdict;
		end
		chk(32'(n), 32'(e));
	endtask
	// ==========
	// scenarios
	task automatic s_regs;
		rchk(`VKD_OFF_CTRL, 32'h4);
		rchk(`VKD_OFF_CLIP, 32'h200);
		rchk(`VKD_OFF_GAIN, 32'h3FF);
		rchk(`VKD_OFF_OPAC, 32'h3FF);
		rchk(`VKD_OFF_POS, 32'h4);
		rchk(`VKD_OFF_SIZE, 32'h0);
		rchk(`VKD_OFF_CORE, 32'h40);
		rchk(8'h28, 32'h0);
		chk(32'(err), 32'h1);
	endtask
	task automatic s_key;
		apb(1, `VKD_OFF_CTRL, 32'h0);
		apb(1, `VKD_OFF_GAIN, 32'h0);
		apb(1, `VKD_OFF_CLIP, 32'h200);
		pix(10'h200, 10'h123, 10'h0, 10'h3FF, 10'h123);
		pix(10'h1FF, 10'h123, 10'h0, 10'h0, 10'h300);
		apb(1, `VKD_OFF_CLIP, 32'h100);
		pix(10'h100, 10'h123, 10'h0, 10'h3FF, 10'h123);
		rchk(`VKD_OFF_GAIN, 32'h0);
		apb(1, `VKD_OFF_CTRL, 32'h8);
		pix(10'h100, 10'h123, 10'h0, 10'h0, 10'h300);
		apb(1, `VKD_OFF_CTRL, 32'h0);
		apb(1, `VKD_OFF_OPAC, 32'h0);
		pix(10'h100, 10'h123, 10'h0, 10'h0, 10'h300);
		apb(1, `VKD_OFF_OPAC, 32'h3FF);
	endtask
	task automatic s_add;
		apb(1, `VKD_OFF_CTRL, 32'h1);
		pix(10'h0FF, 10'h050, 10'h0, 10'h0, 10'h350);
		pix(10'h100, 10'h050, 10'h0, 10'h3FF, 10'h050);
		pix(10'h0FF, 10'h200, 10'h0, 10'h0, 10'h3FF);
		apb(1, `VKD_OFF_CTRL, 32'h11);
		pix(10'h0FF, 10'h030, 10'h0, 10'h0, 10'h300);
	endtask
	task automatic s_mask;
		apb(1, `VKD_OFF_CTRL, 32'h20);
		pix(10'h100, 10'h123, 10'h200, 10'h0, 10'h300);
		apb(1, `VKD_OFF_CTRL, 32'h40);
		pix(10'h0FF, 10'h123, 10'h200, 10'h3FF, 10'h123);
		apb(1, `VKD_OFF_CTRL, 32'hC0);
		pix(10'h0FF, 10'h123, 10'h200, 10'h0, 10'h300);
	endtask
	task automatic s_two;
		apb(1, `VKD_OFF_CTRL, 32'h2);
		apb(1, `VKD_OFF_LOWER, 32'h100);
		apb(1, `VKD_OFF_UPPER, 32'h300);
		rchk(`VKD_OFF_CLIP, 32'h200);
		rchk(`VKD_OFF_GAIN, 32'h200);
		rchk(`VKD_OFF_LOWER, 32'h100);
		pix(10'h300, 10'h123, 10'h0, 10'h3FF, 10'h123);
		pix(10'h100, 10'h123, 10'h0, 10'h0, 10'h300);
		apb(1, `VKD_OFF_LOWER, 32'h0FF);
		rchk(`VKD_OFF_UPPER, 32'h300);
		rchk(`VKD_OFF_LOWER, 32'h0FF);
		apb(1, `VKD_OFF_GAIN, 32'h7FF);
		rchk(`VKD_OFF_GAIN, 32'h7FF);
	endtask
	task automatic s_scrv;
		apb(1, `VKD_OFF_CTRL, 32'h4);
		apb(1, `VKD_OFF_CLIP, 32'h200);
		apb(1, `VKD_OFF_GAIN, 32'h200);
		pix(10'h300, 10'h123, 10'h0, 10'h3FF, 10'h123);
		pix(10'h100, 10'h123, 10'h0, 10'h0, 10'h300);
		pixn(10'h180, 10'h123, 10'h0, 10'h0A0, 10'h2B5);
		pixn(10'h200, 10'h123, 10'h0, 10'h1FF, 10'h212);
		apb(1, `VKD_OFF_CTRL, 32'h0);
		pixn(10'h180, 10'h123, 10'h0, 10'h100, 10'h289);
		pixn(10'h200, 10'h123, 10'h0, 10'h1FF, 10'h212);
	endtask
	task automatic s_pos;
		apb(1, `VKD_OFF_CTRL, 32'h0);
		apb(1, `VKD_OFF_GAIN, 32'h0);
		apb(1, `VKD_OFF_CLIP, 32'h200);
		rise(PMAX_TB + 6);
		apb(1, `VKD_OFF_POS, 32'(PMAX_TB - 2));
		rise(PMAX_TB + 4);
		apb(1, `VKD_OFF_POS, 32'hF);
		rchk(`VKD_OFF_POS, 32'(2 * PMAX_TB));
		rise(2 * PMAX_TB + 6);
		apb(1, `VKD_OFF_POS, 32'(PMAX_TB));
		apb(1, `VKD_OFF_SIZE, 32'h2);
		rise(PMAX_TB + 8);
		apb(1, `VKD_OFF_SIZE, 32'hF);
		rchk(`VKD_OFF_SIZE, 32'h3);
		apb(1, `VKD_OFF_SIZE, 32'h0);
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		s_regs;
		s_key;
		s_add;
		s_mask;
		s_two;
		s_scrv;
		s_pos;
		give_verdict;
	end
endmodule // tb_top
